// ==== logic/core_pkg.sv ====
package core_pkg;

    // data file map
    localparam logic [4:0] ADDR_INDIRECT = 5'h00;
    localparam logic [4:0] ADDR_PC_LOW = 5'h02;
    localparam logic [4:0] ADDR_STATUS = 5'h03;
    localparam logic [4:0] ADDR_POINTER = 5'h04;
    localparam int FILE_WORDS = 32;

    // status field positions
    localparam int BIT_SPARE_PAGE = 7;
    localparam int BIT_PAGE_HI = 6;
    localparam int BIT_PAGE_LO = 5;
    localparam int BIT_TIMEOUT = 4;
    localparam int BIT_SLEEP_ENTERED = 3;
    localparam int BIT_ZERO = 2;
    localparam int BIT_NIBBLE = 1;
    localparam int BIT_CARRY = 0;

    // undefined arithmetic flags come up as zero
    localparam logic [7:0] STATUS_RESET = 8'h18;

    // flag mask layout matches status bits 2..0
    localparam logic [2:0] FLAGS_NONE = 3'h0;
    localparam logic [2:0] FLAGS_Z = 3'h4;
    localparam logic [2:0] FLAGS_C = 3'h1;
    localparam logic [2:0] FLAGS_ALL = 3'h7;

    // instruction cycle timing
    localparam int OSC_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // instruction word fields
    localparam int WORD_BITS = 12;
    localparam int PC_BITS = 11;
    localparam logic [11:0] WORD_NOP = 12'h000;
    localparam logic [4:0] CTRL_SLEEP = 5'h03;
    localparam logic [4:0] CTRL_KICK = 5'h04;
    localparam logic [3:0] TOP_RETURN_LIT = 4'h8;
    localparam logic [3:0] TOP_CALL = 4'h9;
    localparam logic [3:0] TOP_MOVE_LIT = 4'hc;
    localparam logic [3:0] TOP_OR_LIT = 4'hd;
    localparam logic [3:0] TOP_AND_LIT = 4'he;
    localparam logic [3:0] TOP_XOR_LIT = 4'hf;

    typedef enum logic [3:0] {
        FN_PASS_F = 4'b0000,
        FN_PASS_W = 4'b0001,
        FN_ZERO = 4'b0010,
        FN_ADD = 4'b0011,
        FN_SUB = 4'b0100,
        FN_INC = 4'b0101,
        FN_DEC = 4'b0110,
        FN_OR = 4'b0111,
        FN_AND = 4'b1000,
        FN_XOR = 4'b1001,
        FN_COM = 4'b1010,
        FN_RRC = 4'b1011,
        FN_RLC = 4'b1100,
        FN_SWAP = 4'b1101,
        FN_BCLR = 4'b1110,
        FN_BSET = 4'b1111
    } alu_fn_e;

    typedef struct packed {
        logic [7:0] result;
        logic zero;
        logic nibble;
        logic carry;
    } alu_result_s;

    typedef struct packed {
        alu_fn_e fn;
        logic [4:0] file;
        logic [2:0] bitsel;
        logic [8:0] lit;
        logic use_lit;
        logic wr_acc;
        logic wr_file;
        logic [2:0] flag_mask;
        logic skip_on_zero;
        logic skip_bit_set;
        logic skip_bit_clear;
        logic jump;
        logic call;
        logic ret;
        logic sleep;
        logic kick;
    } decoded_s;

endpackage : core_pkg

// ==== logic/alu_unit.sv ====
`timescale 1ns/1ps
module alu_unit (
    input wire core_pkg::alu_fn_e fn,
    input wire logic [7:0] a,
    input wire logic [7:0] w,
    input wire logic [2:0] bitsel,
    input wire logic carry_in,
    output core_pkg::alu_result_s out
);

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] bit_one;

    // one datapath; carry and nibble carry only meaningful where masked in
    always_comb begin
        sum = 9'h000;
        low_sum = 5'h00;
        bit_one = 8'h01 << bitsel;
        out.carry = carry_in;
        out.result = a;
        unique case (fn)
            core_pkg::FN_PASS_F: out.result = a;
            core_pkg::FN_PASS_W: out.result = w;
            core_pkg::FN_ZERO: out.result = 8'h00;
            core_pkg::FN_ADD: begin
                sum = {1'b0, a} + {1'b0, w};
                low_sum = {1'b0, a[3:0]} + {1'b0, w[3:0]};
                out.result = sum[7:0];
                out.carry = sum[8];
            end
            core_pkg::FN_SUB: begin
                sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
                low_sum = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                out.result = sum[7:0];
                out.carry = sum[8];
            end
            core_pkg::FN_INC: out.result = a + 8'h01;
            core_pkg::FN_DEC: out.result = a - 8'h01;
            core_pkg::FN_OR: out.result = a | w;
            core_pkg::FN_AND: out.result = a & w;
            core_pkg::FN_XOR: out.result = a ^ w;
            core_pkg::FN_COM: out.result = ~a;
            core_pkg::FN_RRC: begin
                out.result = {carry_in, a[7:1]};
                out.carry = a[0];
            end
            core_pkg::FN_RLC: begin
                out.result = {a[6:0], carry_in};
                out.carry = a[7];
            end
            core_pkg::FN_SWAP: out.result = {a[3:0], a[7:4]};
            core_pkg::FN_BCLR: out.result = a & ~bit_one;
            core_pkg::FN_BSET: out.result = a | bit_one;
        endcase
        out.zero = (out.result == 8'h00);
        out.nibble = low_sum[4];
    end

endmodule : alu_unit

// ==== logic/core_fragment.sv ====
// Overview of operation
// - flag-setting ops override written arithmetic flags
// - timeout and sleep flags ignore writes
// - clearing status zeroes page bits, sets zero
// - status at 03h, fixed bit layout
// - reset pages zero, timeout/sleep flags one
// - two page bits pick 512-word page
// - bit 7 stores writes, resets zero
// - timeout flag set by kick/sleep, cleared by watchdog
// - sleep flag set by kick, cleared by sleep
// - zero flag follows zero result
// - nibble carry, inverted sense on subtract
// - carry, inverted sense on subtract
// - rotates load carry with shifted bit
// - files reached directly or through pointer
// - twelve-bit words, opcode plus operands
// - file field selects one of 32
// - destination bit picks accumulator or file
// - bit field selects one of eight
// - literal field eight or nine bits
// - one cycle, two on skip, jump, call, return or pc-low write
// - instruction cycle is four clocks
`timescale 1ns/1ps
module core_fragment #(
    parameter logic [10:0] RESET_VECTOR = 11'h000
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [11:0] instr_word,
    input wire logic watchdog_timeout,
    output logic [10:0] program_address,
    output logic cycle_strobe,
    output logic [7:0] acc_value,
    output logic [7:0] status_value,
    output logic sleeping,
    output logic watchdog_kick
);

    // word split into opcode and operand fields
    function automatic core_pkg::decoded_s decode(input logic [11:0] word);
        core_pkg::decoded_s d;
        logic [5:0] op6;
        d = '0;
        op6 = word[11:6];
        d.file = word[4:0];
        d.bitsel = word[7:5];
        d.lit = {1'b0, word[7:0]};
        d.fn = core_pkg::FN_PASS_F;
        if (op6 == 6'h00) begin
            if (word[5]) begin
                // accumulator store leaves flags as written
                d.fn = core_pkg::FN_PASS_W;
                d.wr_file = 1'b1;
            end else begin
                d.sleep = (word[4:0] == core_pkg::CTRL_SLEEP);
                d.kick = (word[4:0] == core_pkg::CTRL_KICK);
            end
        end else if (op6 == 6'h01) begin
            d.fn = core_pkg::FN_ZERO;
            d.wr_file = word[5];
            d.wr_acc = ~word[5];
            d.flag_mask = core_pkg::FLAGS_Z;
        end else if (word[11:10] == 2'b00) begin
            d.wr_file = word[5];
            d.wr_acc = ~word[5];
            d.flag_mask = core_pkg::FLAGS_Z;
            unique case (op6[3:0])
                4'h2: begin
                    d.fn = core_pkg::FN_SUB;
                    d.flag_mask = core_pkg::FLAGS_ALL;
                end
                4'h3: d.fn = core_pkg::FN_DEC;
                4'h4: d.fn = core_pkg::FN_OR;
                4'h5: d.fn = core_pkg::FN_AND;
                4'h6: d.fn = core_pkg::FN_XOR;
                4'h7: begin
                    d.fn = core_pkg::FN_ADD;
                    d.flag_mask = core_pkg::FLAGS_ALL;
                end
                4'h8: d.fn = core_pkg::FN_PASS_F;
                4'h9: d.fn = core_pkg::FN_COM;
                4'ha: d.fn = core_pkg::FN_INC;
                4'hb: begin
                    d.fn = core_pkg::FN_DEC;
                    d.flag_mask = core_pkg::FLAGS_NONE;
                    d.skip_on_zero = 1'b1;
                end
                4'hc: begin
                    d.fn = core_pkg::FN_RRC;
                    d.flag_mask = core_pkg::FLAGS_C;
                end
                4'hd: begin
                    d.fn = core_pkg::FN_RLC;
                    d.flag_mask = core_pkg::FLAGS_C;
                end
                4'he: begin
                    d.fn = core_pkg::FN_SWAP;
                    d.flag_mask = core_pkg::FLAGS_NONE;
                end
                default: begin
                    d.fn = core_pkg::FN_INC;
                    d.flag_mask = core_pkg::FLAGS_NONE;
                    d.skip_on_zero = 1'b1;
                end
            endcase
        end else if (word[11:10] == 2'b01) begin
            unique case (word[9:8])
                2'b00: begin
                    d.fn = core_pkg::FN_BCLR;
                    d.wr_file = 1'b1;
                end
                2'b01: begin
                    d.fn = core_pkg::FN_BSET;
                    d.wr_file = 1'b1;
                end
                2'b10: d.skip_bit_clear = 1'b1;
                default: d.skip_bit_set = 1'b1;
            endcase
        end else if (word[11:9] == 3'b101) begin
            d.lit = word[8:0];
            d.jump = 1'b1;
        end else begin
            d.use_lit = 1'b1;
            d.wr_acc = 1'b1;
            unique case (word[11:8])
                core_pkg::TOP_RETURN_LIT: d.ret = 1'b1;
                core_pkg::TOP_CALL: begin
                    d.wr_acc = 1'b0;
                    d.call = 1'b1;
                end
                core_pkg::TOP_MOVE_LIT: d.fn = core_pkg::FN_PASS_F;
                core_pkg::TOP_OR_LIT: begin
                    d.fn = core_pkg::FN_OR;
                    d.flag_mask = core_pkg::FLAGS_Z;
                end
                core_pkg::TOP_AND_LIT: begin
                    d.fn = core_pkg::FN_AND;
                    d.flag_mask = core_pkg::FLAGS_Z;
                end
                default: begin
                    d.fn = core_pkg::FN_XOR;
                    d.flag_mask = core_pkg::FLAGS_Z;
                end
            endcase
        end
        return d;
    endfunction : decode

    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [10:0] pc;
    logic [10:0] next_pc;
    logic [11:0] exec_word;
    logic [11:0] next_exec_word;
    logic exec_valid;
    logic next_exec_valid;
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] pointer;
    logic [7:0] next_pointer;
    logic [10:0] stack_top;
    logic [10:0] next_stack_top;
    logic [10:0] stack_low;
    logic [10:0] next_stack_low;
    logic next_sleeping;
    logic next_watchdog_kick;
    logic [7:0] file_mem [core_pkg::FILE_WORDS];
    logic file_we;
    logic [4:0] file_addr;
    logic [7:0] file_data;
    core_pkg::decoded_s dec;
    logic [7:0] operand;
    logic execute;
    logic redirect;
    logic test_bit;
    core_pkg::alu_result_s alu;

    alu_unit alu_inst (
        .fn(dec.fn),
        .a(operand),
        .w(acc),
        .bitsel(dec.bitsel),
        .carry_in(status[core_pkg::BIT_CARRY]),
        .out(alu)
    );

    // operand fetch; pointer at file 0 reads as zero to avoid self reference
    always_comb begin
        dec = decode(exec_word);
        file_addr = (dec.file == core_pkg::ADDR_INDIRECT) ? pointer[4:0] : dec.file;
        operand = file_mem[file_addr];
        if (file_addr == core_pkg::ADDR_INDIRECT) begin
            operand = 8'h00;
        end else if (file_addr == core_pkg::ADDR_PC_LOW) begin
            operand = pc[7:0];
        end else if (file_addr == core_pkg::ADDR_STATUS) begin
            operand = status;
        end else if (file_addr == core_pkg::ADDR_POINTER) begin
            operand = pointer;
        end
        if (dec.use_lit) begin
            operand = dec.lit[7:0];
        end
        test_bit = operand[dec.bitsel];
    end

    // core sequencing, one instruction retired per four clocks
    always_comb begin
        next_phase = phase + 2'h1;
        next_pc = pc;
        next_exec_word = exec_word;
        next_exec_valid = exec_valid;
        next_acc = acc;
        next_status = status;
        next_pointer = pointer;
        next_stack_top = stack_top;
        next_stack_low = stack_low;
        next_sleeping = sleeping;
        next_watchdog_kick = 1'b0;
        file_we = 1'b0;
        file_data = alu.result;
        redirect = 1'b0;
        // retire only on the last phase
        execute = (phase == core_pkg::PHASE_LAST) && !sleeping && exec_valid;
        if (watchdog_timeout) begin
            next_status[core_pkg::BIT_TIMEOUT] = 1'b0;
            next_sleeping = 1'b0;
        end
        if (execute) begin
            if (dec.wr_acc) begin
                next_acc = alu.result;
            end
            if (dec.wr_file) begin
                if (file_addr == core_pkg::ADDR_STATUS) begin
                    next_status[7:5] = alu.result[7:5];
                    // non-flag ops write flags as given
                    // timeout and sleep flags not written
                    // any flag-setting op drops all three written flags
                    if (dec.flag_mask == core_pkg::FLAGS_NONE) begin
                        next_status[2:0] = alu.result[2:0];
                    end
                end else if (file_addr == core_pkg::ADDR_POINTER) begin
                    next_pointer = alu.result;
                end else if (file_addr == core_pkg::ADDR_PC_LOW) begin
                    next_pc = {status[core_pkg::BIT_PAGE_HI:core_pkg::BIT_PAGE_LO],
                               1'b0, alu.result};
                    redirect = 1'b1;
                end else if (file_addr != core_pkg::ADDR_INDIRECT) begin
                    file_we = 1'b1;
                end
            end
            // operation flags override the written ones
            // clear of status leaves zero flag set
            if (dec.flag_mask[2]) begin
                next_status[core_pkg::BIT_ZERO] = alu.zero;
            end
            if (dec.flag_mask[1]) begin
                next_status[core_pkg::BIT_NIBBLE] = alu.nibble;
            end
            if (dec.flag_mask[0]) begin
                next_status[core_pkg::BIT_CARRY] = alu.carry;
            end
            // kick and sleep set timeout flag
            // kick sets, sleep clears power-down flag
            if (dec.kick) begin
                next_status[core_pkg::BIT_TIMEOUT] = 1'b1;
                next_status[core_pkg::BIT_SLEEP_ENTERED] = 1'b1;
                next_watchdog_kick = 1'b1;
            end
            if (dec.sleep) begin
                next_status[core_pkg::BIT_TIMEOUT] = 1'b1;
                next_status[core_pkg::BIT_SLEEP_ENTERED] = 1'b0;
                next_sleeping = 1'b1;
                next_watchdog_kick = 1'b1;
                // the held sleep word must not run again on wake
                next_exec_valid = 1'b0;
            end
            // page bits form the upper jump address
            if (dec.jump) begin
                next_pc = {status[core_pkg::BIT_PAGE_HI:core_pkg::BIT_PAGE_LO], dec.lit};
                redirect = 1'b1;
            end
            if (dec.call) begin
                next_stack_low = stack_top;
                next_stack_top = pc;
                next_pc = {status[core_pkg::BIT_PAGE_HI:core_pkg::BIT_PAGE_LO],
                           1'b0, dec.lit[7:0]};
                redirect = 1'b1;
            end
            if (dec.ret) begin
                next_stack_top = stack_low;
                next_pc = stack_top;
                redirect = 1'b1;
            end
            // a true test discards the prefetched word
            if ((dec.skip_on_zero && alu.zero) || (dec.skip_bit_set && test_bit) ||
                (dec.skip_bit_clear && !test_bit)) begin
                redirect = 1'b1;
            end
        end
        // prefetch advances each cycle; a redirect spends the next one idle
        if ((phase == core_pkg::PHASE_LAST) && !sleeping && !next_sleeping) begin
            next_exec_word = instr_word;
            next_exec_valid = !redirect;
            // only a retiring branch or pc-low write owns the counter; skips still advance
            if (!(execute && (dec.jump || dec.call || dec.ret ||
                (dec.wr_file && (file_addr == core_pkg::ADDR_PC_LOW))))) begin
                next_pc = pc + 11'h001;
            end
        end
    end

    // state registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase <= 2'h0;
            pc <= RESET_VECTOR;
            exec_word <= core_pkg::WORD_NOP;
            exec_valid <= 1'b0;
            acc <= 8'h00;
            status <= core_pkg::STATUS_RESET;
            pointer <= 8'h00;
            stack_top <= 11'h000;
            stack_low <= 11'h000;
            sleeping <= 1'b0;
            watchdog_kick <= 1'b0;
        end else begin
            phase <= next_phase;
            pc <= next_pc;
            exec_word <= next_exec_word;
            exec_valid <= next_exec_valid;
            acc <= next_acc;
            status <= next_status;
            pointer <= next_pointer;
            stack_top <= next_stack_top;
            stack_low <= next_stack_low;
            sleeping <= next_sleeping;
            watchdog_kick <= next_watchdog_kick;
        end
    end

    // general files hold no reset; software initialises them
    always_ff @(posedge clock) begin
        if (file_we) begin
            file_mem[file_addr] <= file_data;
        end
    end

    // outputs
    assign program_address = pc;
    assign cycle_strobe = (phase == core_pkg::PHASE_LAST);
    assign acc_value = acc;
    assign status_value = status;

endmodule : core_fragment

// ==== tb/core_fragment_assertions.sv ====
`timescale 1ns/1ps
module core_fragment_assertions #(
    parameter logic [10:0] RESET_VECTOR = 11'h000
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [11:0] instr_word,
    input wire logic watchdog_timeout,
    input wire logic [10:0] program_address,
    input wire logic cycle_strobe,
    input wire logic [7:0] acc_value,
    input wire logic [7:0] status_value,
    input wire logic sleeping,
    input wire logic watchdog_kick
);
    default clocking main_cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_reset_values: assert property (disable iff (1'b0)
        !reset_n |=> status_value == core_pkg::STATUS_RESET && acc_value == 8'h00
        && program_address == RESET_VECTOR) else $error("bad reset values");
    a_strobe_period: assert property (cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
        else $error("strobe period wrong");
    a_quiet_between: assert property (!cycle_strobe && !watchdog_timeout |=>
        $stable(status_value) && $stable(acc_value) && $stable(program_address))
        else $error("state changed off the cycle edge");
    // timeout set only by kick or sleep
    a_timeout_rise: assert property ($rose(status_value[4]) && $past(reset_n) |-> watchdog_kick)
        else $error("timeout flag rose without kick");
    a_timeout_fall: assert property ($fell(status_value[4]) |-> $past(watchdog_timeout))
        else $error("timeout flag fell without expiry");
    a_sleep_flag_fall: assert property ($fell(status_value[3]) |-> sleeping)
        else $error("sleep flag fell while awake");
    a_sleep_flag_rise: assert property ($rose(status_value[3]) && $past(reset_n) |->
        watchdog_kick && !sleeping) else $error("sleep flag rose without kick");
    a_wake_on_expiry: assert property (sleeping && watchdog_timeout |=> !sleeping)
        else $error("no wake on expiry");

    // main scenarios reached
    c_wake: cover property (sleeping && watchdog_timeout);
    c_sleep: cover property ($fell(status_value[3]));
    c_kick: cover property ($rose(status_value[4]));
endmodule : core_fragment_assertions

bind core_fragment core_fragment_assertions #(.RESET_VECTOR(RESET_VECTOR))
    core_fragment_assertions_i (
    .clock(clock), .reset_n(reset_n), .instr_word(instr_word),
    .watchdog_timeout(watchdog_timeout), .program_address(program_address),
    .cycle_strobe(cycle_strobe), .acc_value(acc_value), .status_value(status_value),
    .sleeping(sleeping), .watchdog_kick(watchdog_kick)
);

// ==== tb/test_core_fragment.sv ====
`timescale 1ns/1ps
module test_core_fragment;
    logic clock;
    logic reset_n;
    logic [11:0] instr_word;
    logic watchdog_timeout;
    logic [10:0] program_address;
    logic cycle_strobe;
    logic [7:0] acc_value;
    logic [7:0] status_value;
    logic sleeping;
    logic watchdog_kick;
    int fails;
    int check_count;
    localparam logic [11:0] NOP = core_pkg::WORD_NOP;

    core_fragment core_fragment_i (
        .clock(clock), .reset_n(reset_n), .instr_word(instr_word),
        .watchdog_timeout(watchdog_timeout), .program_address(program_address),
        .cycle_strobe(cycle_strobe), .acc_value(acc_value), .status_value(status_value),
        .sleeping(sleeping), .watchdog_kick(watchdog_kick)
    );

    // 50 ns clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // four-state compare so an unknown never matches
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // land just after the edge that samples instr_word
    task automatic strobe_edge;
        int n;
        n = 0;
        @(negedge clock);
        while (cycle_strobe !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        if (n == 8) fails++;
        @(posedge clock);
    endtask : strobe_edge

    // w retires at the third edge, follow at the fourth
    task automatic exec(input logic [11:0] w, input logic [11:0] follow = NOP);
        strobe_edge();
        instr_word <= w;
        strobe_edge();
        instr_word <= follow;
        strobe_edge();
        instr_word <= NOP;
        strobe_edge();
        @(negedge clock);
    endtask : exec

    // constant to file f through the accumulator
    task automatic put(input logic [7:0] v, input logic [4:0] f);
        exec({4'hc, v});
        exec({7'h01, f});
    endtask : put

    task automatic test_reset;
        check(status_value, 8'h18);
        check(acc_value, 8'h00);
        check(program_address, 11'h000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_status;
        put(8'he7, 5'h03);
        check(status_value, 8'hff);
        put(8'h00, 5'h03);
        check(status_value, 8'h18);
        put(8'h80, 5'h03);
        check(status_value, 8'h98);
        put(8'he3, 5'h03);
        exec({7'h03, 5'h03});
        check(status_value, 8'h1f);
        // add into status overrides written flags
        put(8'h00, 5'h03);
        exec({4'hc, 8'he8});
        exec({6'h07, 1'b1, 5'h03});
        check(status_value, 8'h1f);
        check(acc_value, 8'he8);
        $display("test status done");
    endtask : test_status

    // file 8 holds fv, accumulator wv, result back to accumulator
    task automatic arith(input logic [5:0] op, input logic [7:0] fv, input logic [7:0] wv,
        input logic [7:0] res, input logic [2:0] flags);
        put(fv, 5'h08);
        exec({4'hc, wv});
        exec({op, 1'b0, 5'h08});
        check(acc_value, res);
        check(status_value[2:0], flags);
    endtask : arith

    task automatic test_arith;
        arith(6'h07, 8'h0f, 8'h01, 8'h10, 3'h2);
        arith(6'h07, 8'hf0, 8'h10, 8'h00, 3'h5);
        arith(6'h02, 8'h0f, 8'h10, 8'hff, 3'h2);
        arith(6'h02, 8'h0f, 8'h0f, 8'h00, 3'h7);
        arith(6'h02, 8'h10, 8'h01, 8'h0f, 3'h1);
        arith(6'h0c, 8'h02, 8'h00, 8'h81, 3'h0);
        arith(6'h0d, 8'h80, 8'h00, 8'h00, 3'h1);
        $display("test arith done");
    endtask : test_arith

    task automatic test_indirect;
        put(8'h03, 5'h04);
        put(8'he0, 5'h00);
        check(status_value, 8'hf8);
        exec({4'h4, 3'h7, 5'h03});
        check(status_value, 8'h78);
        exec({4'h5, 3'h0, 5'h03});
        check(status_value, 8'h79);
        $display("test indirect done");
    endtask : test_indirect

    task automatic test_pages;
        for (int p = 0; p < 4; p++) begin
            put({1'b0, p[1:0], 5'h00}, 5'h03);
            // word behind a jump is dropped
            exec({3'h5, 9'h0a5}, {4'hc, 8'h55});
            check(program_address, {p[1:0], 9'h0a6});
            check(acc_value, {1'b0, p[1:0], 5'h00});
        end
        $display("test pages done");
    endtask : test_pages

    task automatic test_skip;
        logic [10:0] start;
        // true skip drops next word, pc keeps advancing
        put(8'hff, 5'h08);
        exec({4'hc, 8'h11});
        start = program_address;
        exec({6'h0f, 1'b1, 5'h08}, {4'hc, 8'h55});
        check(acc_value, 8'h11);
        check(program_address, start + 11'h004);
        // incremented file came back as zero
        exec({6'h08, 1'b0, 5'h08});
        check(acc_value, 8'h00);
        check(status_value[2], 1'b1);
        // call lands in page three, return resumes after it
        start = program_address;
        exec({4'h9, 8'h40});
        check(program_address, 11'h641);
        exec({4'h8, 8'h5a});
        check(program_address, start + 11'h003);
        check(acc_value, 8'h5a);
        $display("test skip done");
    endtask : test_skip

    task automatic test_sleep;
        // sleep clears sleep flag, sets timeout
        exec(12'h003);
        check({sleeping, status_value[4:3]}, 3'h6);
        @(posedge clock);
        watchdog_timeout <= 1'b1;
        @(posedge clock);
        watchdog_timeout <= 1'b0;
        @(negedge clock);
        check({sleeping, status_value[4:3]}, 3'h0);
        exec(12'h004);
        check(status_value[4:3], 2'h3);
        $display("test sleep done");
    endtask : test_sleep

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        reset_n = 1'b0;
        instr_word = NOP;
        watchdog_timeout = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        test_reset();
        test_status();
        test_arith();
        test_indirect();
        test_pages();
        test_skip();
        test_sleep();
        results();
    end

    // hang guard, several times the expected run
    initial begin
        #400us;
        fails++;
        results();
    end
endmodule : test_core_fragment
